/* File: inc/pcsc_consts.svh */
// Purpose: Constants for the PLL clock select control block
// Assumes: AXI4-Lite word registers, 20 MHz aclk
// Notes:   BADDR constants are byte addresses; OFF and IDX constants are word indices
`ifndef PCSC_CONSTS_SVH
`define PCSC_CONSTS_SVH
`define PCSC_ADDR_W          8
`define PCSC_OFF_CTRL        8'h2e
`define PCSC_IDX_CTRL        8'h2e
`define PCSC_BADDR_CTRL      8'hb8
`define PCSC_BADDR_SYNTH     8'hbc
`define PCSC_BADDR_STATUS    8'hc0
`define PCSC_BADDR_MODE      8'hc4
`define PCSC_BIT_PWR         7
`define PCSC_BIT_BSEL        6
`define PCSC_BIT_SELFBW      5
`define PCSC_BIT_WIDEBW      4
`define PCSC_BIT_OSCT        3
`define PCSC_BIT_MSEL        2
`define PCSC_BIT_T16         1
`define PCSC_BIT_WEN         0
`define PCSC_CTRL_RST        7'h2a
`define PCSC_TAP_RST         2'h0
`define PCSC_MODN_RST        6'h0b
`define PCSC_IDLE_TAP        2'h0
`define PCSC_IDLE_MODN       6'h00
`define PCSC_SWITCH_CYC      3'h4
`define PCSC_EDIV_LAST       2'h3
`endif

/* File: inc/pcsc_pkg.sv */
// Purpose: Types for the PLL clock select control block
// Assumes: Constants live in pcsc_consts.svh
// Notes:   Types only
package pcsc_pkg;
  typedef enum logic [1:0] {
    PCSC_MODE_SINGLE,
    PCSC_MODE_EXPANDED,
    PCSC_MODE_BOOT,
    PCSC_MODE_TEST
  } pcsc_mode_e;
  typedef enum logic [1:0] {
    PCSC_SW_IDLE,
    PCSC_SW_DROP,
    PCSC_SW_RAISE
  } pcsc_sw_e;
endpackage : pcsc_pkg

/* File: logic/pcsc_sync2.sv */
// Purpose: Two-stage level synchroniser
// Assumes: Single aclk domain
// Notes:   First stage feeds only the second
`timescale 1ns/1ps
module pcsc_sync2 (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic d,
  output logic      q
);
  logic meta_r;
  logic meta_nxt;
  logic q_nxt;
  always_comb begin
    meta_nxt = d;
    q_nxt    = meta_r;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_r <= meta_nxt;
      q      <= q_nxt;
    end
  end
endmodule : pcsc_sync2

/* File: logic/pcsc_ediv.sv */
// Purpose: Divide-by-four bus phase enable generator
// Assumes: run drops during STOP
// Notes:   phase high in data half, low in internal half
`timescale 1ns/1ps
`include "pcsc_consts.svh"
module pcsc_ediv (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic tick,
  input  wire logic run,
  output logic      phase,
  output logic      cyc_pulse
);
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic       ph_nxt;
  logic       pulse_nxt;
  always_comb begin
    cnt_nxt   = cnt_r;
    ph_nxt    = phase;
    pulse_nxt = 1'b0;
    if (run && tick) begin
      cnt_nxt   = cnt_r + 2'h1;
      ph_nxt    = cnt_nxt[1];
      pulse_nxt = (cnt_r == `PCSC_EDIV_LAST);
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r     <= 2'h0;
      phase     <= 1'b0;
      cyc_pulse <= 1'b0;
    end else begin
      cnt_r     <= cnt_nxt;
      phase     <= ph_nxt;
      cyc_pulse <= pulse_nxt;
    end
  end
endmodule : pcsc_ediv

/* File: logic/pcsc_top.sv */
// Purpose: PLL clock source select and control register block
// Assumes: Source ticks are enable pulses on aclk; AXI4-Lite slave
// Notes:   Analog loop is outside; this block steers its controls
// Operation
// RULE1 - Without PLL source, bus phase runs at reference rate divided by four
// RULE2 - Bus phase low in internal half, high in data half
// RULE3 - STOP halts every clock including bus phase output
// RULE4 - After reset all clocks come from crystal reference
// RULE5 - Pin enable drives quad clock or reference onto pin, chosen by select
// RULE6 - Bit 6 routes oscillator to quad clock when one; reset clears
// RULE7 - Source switch completes within 1.5 reference plus 1.5 oscillator cycles
// RULE8 - Select set ignored while power off; power clear ignored while selected
// RULE9 - Reset loads power bit from the PLL supply pin level
// RULE10 - Self bandwidth bit 5 set by reset; wide bit acts only when clear
// RULE11 - Wide bit turns high bandwidth driver on; low driver always on (code: low driver follows the oscillator test bit)
// RULE12 - Oscillator test set by reset, writable only in boot and test
// RULE13 - Module select feeds serial and timer chain from quad clock or reference
// RULE14 - Timer clock enable gates 16-bit timer clock; resets to one
// RULE15 - With module select clear, modules use reference with synchronised access
// RULE16 - Low power WAIT clears select, idles PLL modulus one, sets wide bit
// RULE17 - Interrupt, reset or enabled receiver activity restores programmed frequency
// RULE18 - Software waits settling time after wake before setting select
// RULE19 - Frequency change follows select off, power off, rewrite, power on, wait
// RULE20 - Software enables PLL in wide bandwidth, narrows after settling
// RULE21 - Feedback multiplier is two times (Y plus 1) times two to X
// RULE22 - Multiplier register readable always, writable only with power off
// RULE23 - Reset clears binary taps and loads modulo field with 001011
// RULE24 - Source multiplexer switches glitch-free through per-source synchronisation
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "pcsc_consts.svh"
module pcsc_top
  import pcsc_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        crystal_tick,
  input  wire logic        osc_tick,
  input  wire logic        pll_supply_pin,
  input  wire logic        quad_pin_output_enable,
  input  wire logic        quad_pin_source_select,
  input  wire logic        stop_mode,
  input  wire logic        wait_exec,
  input  wire logic        irq_any,
  input  wire logic [1:0]  receiver_active_flag,
  input  wire logic [1:0]  receiver_enable_bit,
  input  wire logic [1:0]  op_mode,
  output logic             quad_rate_tick,
  output logic             quad_clock_pin,
  output logic             module_clock_tick,
  output logic             timer16_tick,
  output logic             bus_phase,
  output logic             bus_cycle_pulse,
  output logic             module_access_sync,
  output logic             pll_power_on,
  output logic             pll_hi_bw_driver,
  output logic             pll_lo_bw_enable,
  output logic [1:0]       pll_tap_scale,
  output logic [5:0]       pll_mod_count,
  output logic             pll_idle
);
  // Control register fields
  logic       pwr_r, bsel_r, selfbw_r, widebw_r, osct_r, msel_r, t16_r, wen_r;
  logic       pwr_nxt, bsel_nxt, selfbw_nxt, widebw_nxt, osct_nxt, msel_nxt;
  logic       t16_nxt, wen_nxt;
  logic [1:0] tap_r, tap_nxt;
  logic [5:0] modn_r, modn_nxt;
  logic       idle_r, idle_nxt;
  logic       first_r, first_nxt;
  // Bus slave state
  logic        aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
  logic [7:0]  aw_addr_r, aw_addr_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic        w_lane0_r, w_lane0_nxt;
  logic        bvalid_nxt, rvalid_nxt;
  logic [1:0]  bresp_nxt, rresp_nxt;
  logic [31:0] rdata_nxt;
  // Source switch state
  pcsc_sw_e    sw_r, sw_nxt;
  logic        src_osc_r, src_osc_nxt;
  logic        gate_r, gate_nxt;
  logic        bsel_sync;
  logic        do_wr;
  logic [7:0]  wd;
  logic        phase_w, cyc_w;
  logic        q_tick_nxt, qpin_nxt, m_tick_nxt, t_tick_nxt;
  logic        wake;
  pcsc_mode_e  mode;

  assign mode = pcsc_mode_e'(op_mode);
  assign do_wr = aw_hold_r && w_hold_r && !s_axi_bvalid;
  assign wd    = w_data_r[7:0];
  // An interrupt wakes alone; receiver activity wakes only when that receiver is enabled
  assign wake  = irq_any || |(receiver_active_flag & receiver_enable_bit); // [RULE17]

  // Select reaches the switch through a synchroniser so a change never lands mid-pulse
  pcsc_sync2 u_bsel_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (bsel_r),
    .q       (bsel_sync)
  );

  always_comb begin
    aw_hold_nxt = aw_hold_r;
    w_hold_nxt  = w_hold_r;
    aw_addr_nxt = aw_addr_r;
    w_data_nxt  = w_data_r;
    w_lane0_nxt = w_lane0_r;
    bvalid_nxt  = s_axi_bvalid;
    bresp_nxt   = s_axi_bresp;
    rvalid_nxt  = s_axi_rvalid;
    rresp_nxt   = s_axi_rresp;
    rdata_nxt   = s_axi_rdata;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_nxt  = 1'b1;
      w_data_nxt  = s_axi_wdata;
      w_lane0_nxt = s_axi_wstrb[0];
    end
    if (do_wr) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = 2'h0;
      if (aw_addr_r[7:2] != `PCSC_BADDR_CTRL >> 2 && aw_addr_r[7:2] != `PCSC_BADDR_SYNTH >> 2
          && aw_addr_r[7:2] != `PCSC_BADDR_STATUS >> 2
          && aw_addr_r[7:2] != `PCSC_BADDR_MODE >> 2) begin
        bresp_nxt = 2'h2;
      end
    end else if (s_axi_bvalid && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = 2'h0;
      rdata_nxt  = 32'h0000_0000;
      if (s_axi_araddr[7:2] == `PCSC_BADDR_CTRL >> 2) begin
        rdata_nxt[7:0] = {pwr_r, bsel_r, selfbw_r, widebw_r, osct_r, msel_r, t16_r, wen_r};
      end else if (s_axi_araddr[7:2] == `PCSC_BADDR_SYNTH >> 2) begin
        rdata_nxt[7:0] = {tap_r, modn_r}; // [RULE22]
      end else if (s_axi_araddr[7:2] == `PCSC_BADDR_STATUS >> 2) begin
        rdata_nxt[3:0] = {idle_r, src_osc_r, gate_r, bus_phase};
      end else if (s_axi_araddr[7:2] == `PCSC_BADDR_MODE >> 2) begin
        rdata_nxt[1:0] = op_mode;
      end else begin
        rresp_nxt = 2'h2;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  always_comb begin
    pwr_nxt    = pwr_r;
    bsel_nxt   = bsel_r;
    selfbw_nxt = selfbw_r;
    widebw_nxt = widebw_r;
    osct_nxt   = osct_r;
    msel_nxt   = msel_r;
    t16_nxt    = t16_r;
    wen_nxt    = wen_r;
    tap_nxt    = tap_r;
    modn_nxt   = modn_r;
    idle_nxt   = idle_r;
    first_nxt  = 1'b0;
    // Supply strap is sampled on the first cycle after reset release
    if (first_r) begin
      pwr_nxt = pll_supply_pin; // [RULE9]
    end
    if (do_wr && w_lane0_r && aw_addr_r == `PCSC_BADDR_CTRL) begin
      if (!(wd[`PCSC_BIT_BSEL] && !pwr_r)) begin
        bsel_nxt = wd[`PCSC_BIT_BSEL]; // [RULE8]
      end
      if (!(!wd[`PCSC_BIT_PWR] && bsel_r)) begin
        pwr_nxt = wd[`PCSC_BIT_PWR]; // [RULE8]
      end
      selfbw_nxt = wd[`PCSC_BIT_SELFBW];
      widebw_nxt = wd[`PCSC_BIT_WIDEBW];
      if (mode == PCSC_MODE_BOOT || mode == PCSC_MODE_TEST) begin
        osct_nxt = wd[`PCSC_BIT_OSCT]; // [RULE12]
      end
      msel_nxt = wd[`PCSC_BIT_MSEL];
      t16_nxt  = wd[`PCSC_BIT_T16];
      wen_nxt  = wd[`PCSC_BIT_WEN];
    end
    if (do_wr && w_lane0_r && aw_addr_r == `PCSC_BADDR_SYNTH && !pwr_r) begin
      tap_nxt  = wd[7:6]; // [RULE22]
      modn_nxt = wd[5:0];
    end
    // User modes keep the test bit set
    if (mode == PCSC_MODE_SINGLE || mode == PCSC_MODE_EXPANDED) begin
      osct_nxt = 1'b1; // [RULE12]
    end
    if (wait_exec && wen_r) begin
      bsel_nxt   = 1'b0; // [RULE16]
      widebw_nxt = 1'b1;
      idle_nxt   = 1'b1;
    end else if (idle_r && wake) begin
      idle_nxt = 1'b0; // [RULE17]
    end
  end

  // Break-before-make switch: drop the gate, move the source, raise the gate
  always_comb begin
    sw_nxt      = sw_r;
    src_osc_nxt = src_osc_r;
    gate_nxt    = gate_r;
    case (sw_r)
      PCSC_SW_IDLE: begin
        if (bsel_sync != src_osc_r) begin
          sw_nxt = PCSC_SW_DROP; // [RULE24]
        end
      end
      PCSC_SW_DROP: begin
        if (src_osc_r ? osc_tick : crystal_tick) begin
          gate_nxt    = 1'b0;
          src_osc_nxt = bsel_sync; // [RULE6]
          sw_nxt      = PCSC_SW_RAISE;
        end
      end
      PCSC_SW_RAISE: begin
        if (src_osc_r ? osc_tick : crystal_tick) begin
          gate_nxt = 1'b1; // [RULE7]
          sw_nxt   = PCSC_SW_IDLE;
        end
      end
      default: sw_nxt = PCSC_SW_IDLE;
    endcase
  end

  always_comb begin
    // STOP freezes every derived clock
    q_tick_nxt = !stop_mode && gate_r && (src_osc_r ? osc_tick : crystal_tick); // [RULE3]
    m_tick_nxt = !stop_mode && (msel_r ? q_tick_nxt : crystal_tick); // [RULE13]
    t_tick_nxt = m_tick_nxt && t16_r; // [RULE14]
    qpin_nxt   = quad_pin_output_enable && !stop_mode
                 && (quad_pin_source_select ? crystal_tick : q_tick_nxt); // [RULE5]
  end

  pcsc_ediv u_ediv (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .tick      (q_tick_nxt),
    .run       (!stop_mode), // [RULE3]
    .phase     (phase_w), // [RULE1] [RULE2]
    .cyc_pulse (cyc_w)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_hold_nxt && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_hold_nxt && !(s_axi_wvalid && s_axi_wready);
      s_axi_arready <= !rvalid_nxt && !(s_axi_arvalid && s_axi_arready);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r    <= 1'b0;
      w_hold_r     <= 1'b0;
      aw_addr_r    <= 8'h00;
      w_data_r     <= 32'h0000_0000;
      w_lane0_r    <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= 2'h0;
      s_axi_rdata  <= 32'h0000_0000;
    end else begin
      aw_hold_r    <= aw_hold_nxt;
      w_hold_r     <= w_hold_nxt;
      aw_addr_r    <= aw_addr_nxt;
      w_data_r     <= w_data_nxt;
      w_lane0_r    <= w_lane0_nxt;
      s_axi_bvalid <= bvalid_nxt;
      s_axi_bresp  <= bresp_nxt;
      s_axi_rvalid <= rvalid_nxt;
      s_axi_rresp  <= rresp_nxt;
      s_axi_rdata  <= rdata_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // Reset pattern x010 1010 with power taken from the strap next cycle
      pwr_r     <= 1'b0;
      bsel_r    <= 1'(`PCSC_CTRL_RST >> `PCSC_BIT_BSEL); // [RULE4] [RULE6]
      selfbw_r  <= 1'b1; // [RULE10]
      widebw_r  <= 1'b0; // [RULE11]
      osct_r    <= 1'b1; // [RULE12]
      msel_r    <= 1'b0; // [RULE13]
      t16_r     <= 1'b1; // [RULE14]
      wen_r     <= 1'b0;
      tap_r     <= `PCSC_TAP_RST; // [RULE23]
      modn_r    <= `PCSC_MODN_RST; // [RULE23]
      idle_r    <= 1'b0; // [RULE17]
      first_r   <= 1'b1;
      sw_r      <= PCSC_SW_IDLE;
      src_osc_r <= 1'b0; // [RULE4]
      gate_r    <= 1'b1;
    end else begin
      pwr_r     <= pwr_nxt;
      bsel_r    <= bsel_nxt;
      selfbw_r  <= selfbw_nxt;
      widebw_r  <= widebw_nxt;
      osct_r    <= osct_nxt;
      msel_r    <= msel_nxt;
      t16_r     <= t16_nxt;
      wen_r     <= wen_nxt;
      tap_r     <= tap_nxt;
      modn_r    <= modn_nxt;
      idle_r    <= idle_nxt;
      first_r   <= first_nxt;
      sw_r      <= sw_nxt;
      src_osc_r <= src_osc_nxt;
      gate_r    <= gate_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      quad_rate_tick     <= 1'b0;
      quad_clock_pin     <= 1'b0;
      module_clock_tick  <= 1'b0;
      timer16_tick       <= 1'b0;
      bus_phase          <= 1'b0;
      bus_cycle_pulse    <= 1'b0;
      module_access_sync <= 1'b1;
      pll_power_on       <= 1'b0;
      pll_hi_bw_driver   <= 1'b0;
      pll_lo_bw_enable   <= 1'b1;
      pll_tap_scale      <= `PCSC_TAP_RST;
      pll_mod_count      <= `PCSC_MODN_RST;
      pll_idle           <= 1'b0;
    end else begin
      quad_rate_tick     <= q_tick_nxt;
      quad_clock_pin     <= qpin_nxt;
      module_clock_tick  <= m_tick_nxt;
      timer16_tick       <= t_tick_nxt;
      bus_phase          <= phase_w;
      bus_cycle_pulse    <= cyc_w;
      module_access_sync <= !msel_r; // [RULE15]
      pll_power_on       <= pwr_r;
      // Self bandwidth hands the filter to the analog loop; wide bit then has no say
      pll_hi_bw_driver   <= !selfbw_r && widebw_r; // [RULE10] [RULE11]
      pll_lo_bw_enable   <= osct_r; // [RULE12]
      // Idle forces modulus one; the multiplier is 2*(Y+1)*2^X in the loop
      pll_tap_scale      <= idle_r ? `PCSC_IDLE_TAP : tap_r; // [RULE16] [RULE21]
      pll_mod_count      <= idle_r ? `PCSC_IDLE_MODN : modn_r; // [RULE21]
      pll_idle           <= idle_r;
    end
  end
endmodule : pcsc_top

/* File: dv/pcsc_props.sv */
// Purpose: Port-level checks for the PLL clock select control block
// Assumes: Single aclk domain; tick outputs registered one cycle after their source
// Notes:   Bound to pcsc_top from the bench top file
`timescale 1ns/1ps
module pcsc_props (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       crystal_tick,
  input wire logic       osc_tick,
  input wire logic       quad_pin_output_enable,
  input wire logic       quad_pin_source_select,
  input wire logic       stop_mode,
  input wire logic       wait_exec,
  input wire logic       irq_any,
  input wire logic [1:0] receiver_active_flag,
  input wire logic [1:0] receiver_enable_bit,
  input wire logic [1:0] op_mode,
  input wire logic       quad_rate_tick,
  input wire logic       quad_clock_pin,
  input wire logic       module_clock_tick,
  input wire logic       timer16_tick,
  input wire logic       bus_cycle_pulse,
  input wire logic       module_access_sync,
  input wire logic       pll_power_on,
  input wire logic       pll_lo_bw_enable,
  input wire logic [1:0] pll_tap_scale,
  input wire logic [5:0] pll_mod_count,
  input wire logic       pll_idle
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_stop_halts: assert property (
    stop_mode[*3] |-> !quad_rate_tick && !bus_cycle_pulse && !module_clock_tick)
    else $error("clock tick during stop");
  chk_pin_quad: assert property (
    $past(quad_pin_output_enable) && !$past(quad_pin_source_select)
    |-> quad_clock_pin == quad_rate_tick) else $error("pin not quad clock");
  chk_pin_off: assert property (
    !$past(quad_pin_output_enable) |-> !quad_clock_pin) else $error("pin driven while off");
  chk_module_ref: assert property (
    $past(aresetn) && module_access_sync && $past(module_access_sync) && !$past(stop_mode)
    |-> module_clock_tick == $past(crystal_tick)) else $error("module tick not reference");
  chk_timer_gate: assert property (
    timer16_tick |-> module_clock_tick) else $error("timer tick without module tick");
  chk_tick_source: assert property (
    quad_rate_tick |-> $past(crystal_tick) || $past(osc_tick)) else $error("stray quad tick");
  chk_power_off_ref: assert property (
    (!pll_power_on && !stop_mode)[*8] |-> quad_rate_tick == $past(crystal_tick))
    else $error("oscillator used with power off");
  chk_idle_mult: assert property (
    pll_idle && $past(pll_idle) |-> pll_tap_scale == 2'h0 && pll_mod_count == 6'h00)
    else $error("idle modulus not one");
  chk_idle_cause: assert property (
    $rose(pll_idle) |-> $past(wait_exec) || $past(wait_exec, 2) || $past(wait_exec, 3))
    else $error("idle without wait");
  chk_wake_bound: assert property (
    pll_idle && !wait_exec && !$past(wait_exec)
    && (irq_any || (receiver_active_flag & receiver_enable_bit) != 2'b00)
    |-> ##[1:4] !pll_idle) else $error("no wake");
  chk_user_lo_bw: assert property (
    !op_mode[1] [*3] |-> pll_lo_bw_enable) else $error("low band off in user mode");
endmodule : pcsc_props

/* File: dv/test_pll_clock_select_control.sv */
// Purpose: Self-checking bench for the PLL clock select control block
// Assumes: Crystal tick every third aclk, random oscillator ticks
// Notes:   Register model applies the interlocks itself; nothing is copied from reads
`timescale 1ns/1ps
`include "pcsc_consts.svh"
module test_pll_clock_select_control;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, crystal_tick, osc_tick, pll_supply_pin, quad_pin_output_enable;
  logic        quad_pin_source_select, stop_mode, wait_exec, irq_any, quad_rate_tick;
  logic        quad_clock_pin, module_clock_tick, timer16_tick, bus_phase, bus_cycle_pulse;
  logic        module_access_sync, pll_power_on, pll_hi_bw_driver, pll_lo_bw_enable, pll_idle;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, ctrl_m, syn_m;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, receiver_active_flag, receiver_enable_bit, op_mode, rr;
  logic [1:0]  pll_tap_scale;
  logic [5:0]  pll_mod_count;
  logic        idle_m;
  integer      seed;
  int          failures, n_compared, tcnt, k, n, cry, hi, mt, tt, qt;

  pcsc_top u_dut (.*);

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // Irregular oscillator ticks exercise the switch under uneven spacing
  always @(posedge aclk) begin
    tcnt <= (tcnt == 2) ? 0 : tcnt + 1;
    crystal_tick <= (tcnt == 0);
    osc_tick <= 1'($random(seed));
    quad_pin_output_enable <= 1'($random(seed));
    quad_pin_source_select <= 1'($random(seed));
  end

  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic tmo(input int c);
    if (c > 400) begin
      failures++;
      $display("BAD wait expected answer seen none");
      report_and_stop();
    end
  endtask : tmo

  // Address and data offered together; each released at its own handshake
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
    int c;
    c = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      c++;
      tmo(c);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    int c;
    c = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      c++;
      tmo(c);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input string nm);
    axi_rd(a);
    chk(nm, {24'h00_0000, e}, rd);
    chk("rresp", 32'h0000_0000, {30'h0000_0000, rr});
  endtask : rdchk

  task automatic do_reset(input logic sup);
    @(posedge aclk);
    aresetn <= 1'b0;
    pll_supply_pin <= sup;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    ctrl_m = {sup, 7'h2a};
    syn_m = 8'h0b;
    idle_m = 1'b0;
    repeat (3) @(posedge aclk);
  endtask : do_reset

  task automatic wctrl(input logic [7:0] d, input logic [3:0] s);
    logic [7:0] x;
    x = d;
    if (!ctrl_m[7]) x[6] = 1'b0;
    if (ctrl_m[6]) x[7] = 1'b1;
    if (!op_mode[1]) x[3] = 1'b1;
    if (s[0]) ctrl_m = x;
    axi_wr(`PCSC_BADDR_CTRL, d, s);
    chk("bresp", 32'h0000_0000, {30'h0000_0000, rr});
    rdchk(`PCSC_BADDR_CTRL, ctrl_m, "ctrl");
  endtask : wctrl

  task automatic wsyn(input logic [7:0] d);
    if (!ctrl_m[7]) syn_m = d;
    axi_wr(`PCSC_BADDR_SYNTH, d, 4'hf);
    rdchk(`PCSC_BADDR_SYNTH, syn_m, "synth");
  endtask : wsyn

  task automatic chk_outs;
    repeat (3) @(posedge aclk);
    chk("power", ctrl_m[7], pll_power_on);
    chk("hi_bw", !ctrl_m[5] && ctrl_m[4], pll_hi_bw_driver);
    chk("lo_bw", ctrl_m[3], pll_lo_bw_enable);
    chk("mod_sync", !ctrl_m[2], module_access_sync);
    chk("mult", idle_m ? 8'h00 : syn_m, {pll_tap_scale, pll_mod_count});
  endtask : chk_outs

  // Counts over exactly five bus cycles, so edge alignment cancels out
  task automatic measure;
    int c, p;
    c = 0;
    p = 0;
    cry = 0;
    hi = 0;
    mt = 0;
    tt = 0;
    qt = 0;
    do begin
      @(posedge aclk);
      c++;
      tmo(c);
    end while (!bus_cycle_pulse);
    while (p < 5) begin
      cry += crystal_tick;
      hi += bus_phase;
      mt += module_clock_tick;
      tt += timer16_tick;
      qt += quad_rate_tick;
      @(posedge aclk);
      c++;
      tmo(c);
      p += bus_cycle_pulse;
    end
  endtask : measure

  initial begin
    seed = 32'h8790;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {stop_mode, wait_exec, irq_any, receiver_active_flag, receiver_enable_bit} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, op_mode} = '0;
    pll_supply_pin = 1'b1;
    for (k = 1; k >= 0; k--) begin
      do_reset(k[0]);
      rdchk(`PCSC_BADDR_CTRL, ctrl_m, "ctrl_rst");
      rdchk(`PCSC_BADDR_SYNTH, 8'h0b, "syn_rst");
      chk_outs();
    end
    $display("test reset done");
    wctrl(8'h6a, 4'h1);
    wsyn(8'($random(seed)));
    chk_outs();
    wctrl(8'haa, 4'h1);
    wsyn(8'($random(seed)));
    wctrl(8'hea, 4'h1);
    repeat (20) @(posedge aclk);
    axi_rd(`PCSC_BADDR_STATUS);
    chk("src_osc", 32'h1, rd[2]);
    wctrl(8'h2a, 4'h1);
    wctrl(8'h00, 4'h0);
    axi_rd(8'hd0);
    chk("bad_rd", 32'h2, rr);
    axi_wr(8'hd0, 8'hff, 4'hf);
    chk("bad_wr", 32'h2, rr);
    $display("test interlock done");
    for (k = 0; k < 4; k++) begin
      op_mode <= 2'(k);
      @(posedge aclk);
      wctrl(ctrl_m & 8'hf7, 4'h1);
      rdchk(`PCSC_BADDR_MODE, 8'(k), "mode");
      chk_outs();
    end
    wctrl(ctrl_m | 8'h08, 4'h1);
    op_mode <= 2'h0;
    @(posedge aclk);
    for (k = 0; k < 4; k++) begin
      wctrl({ctrl_m[7:6], 2'(k), ctrl_m[3:0]}, 4'h1);
      chk_outs();
    end
    $display("test mode and band done");
    wctrl(ctrl_m | 8'h41, 4'h1);
    for (k = 0; k < 3; k++) begin
      @(posedge aclk);
      wait_exec <= 1'b1;
      @(posedge aclk);
      wait_exec <= 1'b0;
      ctrl_m[6] = 1'b0;
      ctrl_m[4] = 1'b1;
      idle_m = 1'b1;
      repeat (4) @(posedge aclk);
      chk("idle", 32'h1, pll_idle);
      rdchk(`PCSC_BADDR_CTRL, ctrl_m, "ctrl_wait");
      n = $random(seed) & 1;
      irq_any <= (k == 0);
      receiver_active_flag <= (k > 0) ? 2'(1 << n) : 2'b00;
      receiver_enable_bit <= (k == 2) ? 2'(1 << n) : ~2'(1 << n);
      repeat (5) @(posedge aclk);
      chk("woken", k != 1, !pll_idle);
      idle_m = (k == 1);
      irq_any <= 1'b0;
      receiver_active_flag <= 2'b00;
      chk_outs();
    end
    repeat (40) @(posedge aclk);
    wctrl(ctrl_m | 8'h40, 4'h1);
    $display("test wait done");
    do_reset(1'b0);
    measure();
    chk("ref_ticks", 32'd20, cry);
    chk("phase_hi", 32'd30, hi);
    chk("mod_ticks", 32'd20, mt);
    chk("t16_on", 32'd20, tt);
    wctrl(8'h28, 4'h1);
    measure();
    chk("t16_off", 32'd0, tt);
    stop_mode <= 1'b1;
    repeat (3) @(posedge aclk);
    qt = 0;
    repeat (30) begin
      @(posedge aclk);
      qt += quad_rate_tick + bus_cycle_pulse;
    end
    chk("stop_ticks", 32'd0, qt);
    stop_mode <= 1'b0;
    wsyn(8'h0b);
    wctrl(8'hb8, 4'h1);
    repeat (40) @(posedge aclk);
    wctrl(8'hee, 4'h1);
    measure();
    chk("quad_ticks", 32'd20, qt);
    chk("mod_quad", 32'd20, mt);
    $display("test clocks done");
    report_and_stop();
  end
endmodule : test_pll_clock_select_control

bind pcsc_top pcsc_props u_props (.*);
